//--- logic/ebc_regs.vh
// break control constants: widths, reset values, event codes
// assumes inclusion by the break control design files, checker and bench
`ifndef EBC_REGS_VH
`define EBC_REGS_VH
`define EBC_ADDR_W 12
`define EBC_CNT_W 8
`define EBC_CNT_RST 8'h00
`define EBC_EDGE_RISE 1'b0
`define EBC_EDGE_FALL 1'b1
`define EBC_CAUSE_W 2
`define EBC_CAUSE_NONE 2'h0
`define EBC_CAUSE_HW 2'h1
`define EBC_CAUSE_FORCE 2'h2
`define EBC_CAUSE_TRIG 2'h3
`endif

//--- logic/ebc_trig_edge.v
// external trigger edge detector, shared by trace and break
// assumes trigger input already synchronous to sys_clk
`timescale 1ns/10ps
module ebc_trig_edge (
   input wire sys_clk,
   input wire rst,
   input wire trigIn,
   input wire edgeSel,
   output wire trigEvent
);
`include "ebc_regs.vh"
   reg trigPrev_q;
   always @(posedge sys_clk) begin
      if (rst) begin
         // follow the pin during reset so an idle-high input gives no false edge
         trigPrev_q <= trigIn;
      end else begin
         trigPrev_q <= trigIn;
      end
   end
   // leading or trailing edge by selection
   assign trigEvent = (edgeSel == `EBC_EDGE_RISE) ? (trigIn & ~trigPrev_q) : (~trigIn & trigPrev_q);
endmodule

//--- logic/ebc_break_ctrl.v
// break control for emulation run commands: hardware, pass-count, forced and trigger breaks
// assumes one fetch strobe per instruction from the emulator core, inputs synchronous to sys_clk
`timescale 1ns/10ps
`include "ebc_regs.vh"
// Operation
// - breakpoint inside a chained instruction run does not halt during the run
// - chained-run breakpoint halts after first address beyond run is fetched, before executing
// - forced or trigger break halts even inside a chained run
// - such a break stops at address directly after the current instruction
// - breakpoint on a skipped instruction never halts
// - pass count decrements and halts only when instruction really executes
// - trigger break fires on selected rising or falling edge
// - one trigger input serves both trace and break
// - serial emulation offers internal-clock synchronous mode only
module ebc_break_ctrl (
   input wire sys_clk,
   input wire rst,
   input wire runCmd,
   input wire run_with_breaks_command,
   input wire stopCmd,
   input wire fetchValid,
   input wire [`EBC_ADDR_W-1:0] fetchAddr,
   input wire fetchChained,
   input wire fetchSkipped,
   input wire [`EBC_ADDR_W-1:0] bpAddr,
   input wire bpEnable,
   input wire [`EBC_CNT_W-1:0] bpPassCount,
   input wire bpLoad,
   input wire forceBreak,
   input wire trigIn,
   input wire trigEdgeSel,
   input wire trigBreakEn,
   input wire serialExtClkReq,
   output reg running,
   output reg breakHalt,
   output reg [`EBC_ADDR_W-1:0] haltAddr,
   output reg [`EBC_ADDR_W-1:0] resumeHint,
   output reg [`EBC_CAUSE_W-1:0] breakCause,
   output wire traceTrig,
   output wire serialExtClkOk
);
   // ==========================================
   // state
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_HALT = 2'd2;
   reg [1:0] state_q;
   reg hwPending_q;
   reg asyncPending_q;
   reg [`EBC_CAUSE_W-1:0] asyncCause_q;
   reg chainPrev_q;
   reg [`EBC_CNT_W-1:0] passLeft_q;
   wire trigEvent;
   wire bpHit;
   wire passDone;
   wire hwFire;
   // ==========================================
   // shared trigger
   ebc_trig_edge trigEdge (
      .sys_clk(sys_clk),
      .rst(rst),
      .trigIn(trigIn),
      .edgeSel(trigEdgeSel),
      .trigEvent(trigEvent)
   );
   assign traceTrig = trigEvent;
   // external-clock serial mode is never granted
   assign serialExtClkOk = 1'b0;
   // ==========================================
   // hardware breakpoint match
   // skipped fetches never match or count
   assign bpHit = bpEnable & fetchValid & ~fetchSkipped & (fetchAddr == bpAddr);
   assign passDone = (passLeft_q <= 8'h01);
   assign hwFire = bpHit & passDone;
   always @(posedge sys_clk) begin
      if (rst) begin
         passLeft_q <= `EBC_CNT_RST;
      end else if (bpLoad) begin
         passLeft_q <= bpPassCount;
      end else if (state_q == ST_RUN && bpHit && !passDone) begin
         passLeft_q <= passLeft_q - 8'h01;
      end
   end
   // ==========================================
   // run and halt sequencing
   // hw break deferred while chain continues; acts on first fetch past it
   always @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         hwPending_q <= 1'b0;
         asyncPending_q <= 1'b0;
         asyncCause_q <= `EBC_CAUSE_NONE;
         chainPrev_q <= 1'b0;
         running <= 1'b0;
         breakHalt <= 1'b0;
         haltAddr <= {`EBC_ADDR_W{1'b0}};
         resumeHint <= {`EBC_ADDR_W{1'b0}};
         breakCause <= `EBC_CAUSE_NONE;
      end else begin
         breakHalt <= 1'b0;
         case (state_q)
            ST_IDLE, ST_HALT: begin
               if (runCmd || run_with_breaks_command) begin
                  state_q <= ST_RUN;
                  running <= 1'b1;
                  hwPending_q <= 1'b0;
                  asyncPending_q <= 1'b0;
                  chainPrev_q <= 1'b0;
                  breakCause <= `EBC_CAUSE_NONE;
               end
            end
            ST_RUN: begin
               // async requests latched, honoured at next fetch even mid-chain
               if (forceBreak) begin
                  asyncPending_q <= 1'b1;
                  asyncCause_q <= `EBC_CAUSE_FORCE;
               end else if (trigEvent && trigBreakEn && run_with_breaks_command) begin
                  asyncPending_q <= 1'b1;
                  asyncCause_q <= `EBC_CAUSE_TRIG;
               end
               if (stopCmd) begin
                  state_q <= ST_HALT;
                  running <= 1'b0;
               end else if (fetchValid) begin
                  chainPrev_q <= fetchChained;
                  if (asyncPending_q) begin
                     // stop at the address following the current instruction
                     state_q <= ST_HALT;
                     running <= 1'b0;
                     breakHalt <= 1'b1;
                     haltAddr <= fetchAddr;
                     breakCause <= asyncCause_q;
                     asyncPending_q <= 1'b0;
                     // restart point: caller must move past the run
                     resumeHint <= fetchAddr;
                  // last member of a run still belongs to it; wait for the fetch past it
                  end else if ((hwPending_q || hwFire) && !fetchChained && !chainPrev_q) begin
                     state_q <= ST_HALT;
                     running <= 1'b0;
                     breakHalt <= 1'b1;
                     haltAddr <= fetchAddr;
                     resumeHint <= fetchAddr;
                     breakCause <= `EBC_CAUSE_HW;
                     hwPending_q <= 1'b0;
                  end else if (hwFire) begin
                     hwPending_q <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               running <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- sim/ebc_break_sva.sv
// checker for the break control block, bound to ebc_break_ctrl
// assumes one clock, sync reset high
`timescale 1ns/10ps
`include "ebc_regs.vh"
module ebc_break_sva (
   input wire sys_clk, rst, running, breakHalt, fetchValid, fetchChained, fetchSkipped,
   input wire forceBreak, bpEnable, trigIn, trigEdgeSel, trigBreakEn, run_with_breaks_command,
   input wire traceTrig, serialExtClkOk,
   input wire [11:0] fetchAddr, haltAddr,
   input wire [1:0] breakCause
);
   // ====
   // properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire hwHalt = breakHalt && breakCause == `EBC_CAUSE_HW;
   // event arrives on a fetched instruction; halt lands on the fetch after it
   sequence forceSeq;
      running && forceBreak && !bpEnable && fetchValid ##1 running && fetchValid;
   endsequence
   sequence trigSeq;
      running && run_with_breaks_command && trigBreakEn && traceTrig && !forceBreak && fetchValid
         ##1 running && fetchValid;
   endsequence
   chk_chain_hold: assert property (fetchValid && fetchChained |=> !hwHalt)
      else $error("hw halt in chain");
   chk_halt_pulse: assert property (breakHalt |-> !running ##1 !breakHalt)
      else $error("halt pulse");
   chk_force_halt: assert property (forceSeq |=> breakHalt && breakCause == `EBC_CAUSE_FORCE)
      else $error("no force halt");
   chk_force_addr: assert property (forceSeq |=> haltAddr == $past(fetchAddr, 2) + 12'h001)
      else $error("force addr");
   chk_skip_quiet: assert property (fetchValid && fetchSkipped && !fetchChained |=> !hwHalt)
      else $error("skip halted");
   chk_trig_halt: assert property (trigSeq |=> breakHalt && breakCause == `EBC_CAUSE_TRIG)
      else $error("no trig halt");
   chk_edge_sel: assert property (!$past(rst) |-> traceTrig == (trigEdgeSel ? $fell(trigIn) : $rose(trigIn)))
      else $error("trace edge");
   chk_serial_int: assert property (serialExtClkOk == 1'b0)
      else $error("ext clock serial");
   cov_force: cover property (breakHalt && breakCause == `EBC_CAUSE_FORCE);
   cov_trig: cover property (breakHalt && breakCause == `EBC_CAUSE_TRIG);
   cov_hw: cover property (hwHalt);
endmodule
bind ebc_break_ctrl ebc_break_sva chk (.*);

//--- sim/ebc_core_model.sv
// fetch stream model of the emulator core
// assumes restart address comes from the bench
`timescale 1ns/10ps
module ebc_core_model (
   input wire sys_clk,
   input wire running,
   input wire [11:0] startAddr,
   input wire [15:0] chainMap,
   input wire [15:0] skipMap,
   output logic fetchValid = 1'b0,
   output wire [11:0] fetchAddr,
   output wire fetchChained,
   output wire fetchSkipped
);
   // ====
   // sequencer; four-bit wrap revisits a breakpoint every 16 fetches
   logic [3:0] pc_q = 4'h0;
   // main clock never stopped nor switched to another source by the modelled program
   always @(posedge sys_clk) begin
      fetchValid <= running;
      pc_q <= fetchValid ? pc_q + 4'h1 : startAddr[3:0];
   end
   // idle address inverted, never a stale fetch
   assign fetchAddr = fetchValid ? {8'h00, pc_q} : {8'hFF, ~pc_q};
   assign fetchChained = fetchValid & chainMap[pc_q];
   assign fetchSkipped = fetchValid & skipMap[pc_q];
endmodule

//--- sim/testbench.sv
// scenario bench for the break control block
// assumes core model and bound checker
`timescale 1ns/10ps
`include "ebc_regs.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
   logic sys_clk = 0, rst = 1, runCmd = 0, run_with_breaks_command = 0, stopCmd = 0, bpEnable = 0, bpLoad = 0;
   logic forceBreak = 0, trigIn = 0, trigEdgeSel = 0, trigBreakEn = 0, serialExtClkReq = 1;
   logic fetchValid, fetchChained, fetchSkipped, running, breakHalt, traceTrig, serialExtClkOk;
   logic [11:0] bpAddr = 0, startAddr = 0, fetchAddr, haltAddr, resumeHint;
   logic [7:0] bpPassCount = 0;
   logic [15:0] chainMap = 0, skipMap = 0;
   logic [1:0] breakCause;
   int err_total = 0, samples_checked = 0, n;
   ebc_break_ctrl uut (.*);
   ebc_core_model core (.*);
   always #12.5 sys_clk = ~sys_clk;
   // ====
   // helpers
   task tick; @(posedge sys_clk); #2; endtask
   task go(input logic [11:0] a, input logic t);
      startAddr = a; tick; runCmd = !t; run_with_breaks_command = t; tick; runCmd = 0;
   endtask
   task wait_halt;
      for (n = 0; n < 300 && breakHalt !== 1'b1; n++) tick;
      `CHK("halt", 1'b1, breakHalt)
   endtask
   task done(input string s); $display("%s done", s); repeat (3) tick; endtask
   // ====
   // scenarios
   task t_chain;
      bpAddr = 12'h003; bpEnable = 1; go(12'h000, 0); wait_halt;
      `CHK("addr", 12'h003, haltAddr)
      `CHK("cause", `EBC_CAUSE_HW, breakCause)
      chainMap = 16'h0006; bpAddr = 12'h002; go(12'h000, 0); wait_halt;
      `CHK("chain addr", 12'h004, haltAddr)
      done("chain");
   endtask
   task t_force;
      bpEnable = 0; go(12'h001, 0); tick; forceBreak = 1; tick; forceBreak = 0; wait_halt;
      `CHK("force", `EBC_CAUSE_FORCE, breakCause)
      `CHK("force addr", 12'h002, haltAddr)
      `CHK("hint", 12'h002, resumeHint)
      done("force"); go(12'h004, 0); // restart past the chain
      `CHK("rerun", 1'b1, running)
      tick;
      `CHK("rerun addr", 12'h004, fetchAddr)
      stopCmd = 1; tick; stopCmd = 0; done("restart");
   endtask
   task t_trig;
      trigBreakEn = 1;
      for (int s = 0; s < 2; s++) begin
         trigEdgeSel = s[0]; trigIn = s[0]; go(12'h008, 1); tick; trigIn = !s[0]; #1;
         `CHK("trace", 1'b1, traceTrig)
         wait_halt;
         `CHK("trig", `EBC_CAUSE_TRIG, breakCause)
         `CHK("trig addr", 12'h009, haltAddr)
         run_with_breaks_command = 0; done("trig");
      end
   endtask
   task t_pass;
      chainMap = 0; skipMap = 16'h0020; bpAddr = 12'h005; bpEnable = 1; bpPassCount = 8'h02; bpLoad = 1; tick;
      bpLoad = 0; go(12'h000, 0); repeat (10) tick; skipMap = 0; wait_halt;
      `CHK("late halt", 1'b1, n > 20)
      `CHK("pass addr", 12'h005, haltAddr)
      done("pass");
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) tick; rst = 0;
      t_chain; t_force; t_trig; t_pass; give_verdict;
   end
   initial begin
      #100000; err_total++; give_verdict;
   end
endmodule
